//--- logic/pgu_pkg.sv
package pgu_pkg;

  // ==========================================================================
  // Geometry
  // ==========================================================================
  localparam int unsigned PAGE_NUM_W = 12;
  localparam int unsigned PAGE_COUNT = 4096;
  localparam int unsigned PAGE_OFS_W = 12;
  localparam int unsigned MAX_PROCS = 15;
  localparam int unsigned CTX_W = 4;

  // ==========================================================================
  // Control word bit positions for usage-table writes
  // ==========================================================================
  localparam int unsigned CTL_MOD_BIT = 14;
  localparam int unsigned CTL_REF_BIT = 15;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [1:0] USAGE_RST = 2'h0;

  // One translated host access as presented for checking.
  typedef struct packed {
    logic valid;
    logic write;
    logic mapped;
    logic ptab_res;
    logic legal;
    logic page_res;
    logic [PAGE_NUM_W-1:0] ppn;
  } pgu_access_t;

  // One software table operation on the usage table.
  typedef struct packed {
    logic valid;
    logic write;
    logic [PAGE_NUM_W-1:0] ppn;
    logic [15:0] ctl;
  } pgu_swop_t;

  // Outcome of a checked access.
  typedef enum logic [1:0] {
    PGU_OK,
    PGU_UNMAPPED,
    PGU_ILLEGAL,
    PGU_NOTRES
  } pgu_result_t;

endpackage

//--- logic/pgu_usage_ram.sv
`timescale 1ns/1ps

// Two-bit wide usage memory; read data leave through a register.
module pgu_usage_ram #(
  parameter int unsigned DEPTH = 4096,
  parameter int unsigned AW = 12
) (
  // Clock
  input wire logic clk_i,
  // Read port
  input wire logic [AW-1:0] raddr_i,
  output logic [1:0] rdata_o,
  // Write port
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [1:0] wdata_i
);

  logic [1:0] mem_q [DEPTH];

  // Registered read and plain write; no reset so it maps onto block memory.
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
    rdata_o <= mem_q[raddr_i];
  end

endmodule // pgu_usage_ram

//--- logic/pgu_core.sv
`timescale 1ns/1ps

module pgu_core #(
  parameter int unsigned PAGES = pgu_pkg::PAGE_COUNT
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Mapping control
  input wire logic map_en_i,
  input wire logic [pgu_pkg::CTX_W-1:0] ctx_i,
  // Translated host access
  input wire pgu_pkg::pgu_access_t acc_i,
  // Software table operation
  input wire pgu_pkg::pgu_swop_t sw_i,
  // Fault answer
  output logic bus_err_o,
  output logic page_fault_o,
  output pgu_pkg::pgu_result_t result_o,
  output logic result_vld_o,
  // Software read answer and context flag
  output logic [1:0] sw_rdata_o,
  output logic sw_rvld_o,
  output logic ctx_bad_o
);

  // ==========================================================================
  // Access classification
  // ==========================================================================
  pgu_pkg::pgu_result_t res_d;
  logic touch_d;

  // Residency and table fields arrive as inputs only; no path drives them back.
  // Order of checks: mapped, table resident, legality, page resident.
  always_comb begin
    res_d = pgu_pkg::PGU_OK;
    if (!acc_i.mapped) begin
      res_d = pgu_pkg::PGU_UNMAPPED;
    end else if (!acc_i.ptab_res) begin
      res_d = pgu_pkg::PGU_NOTRES;
    end else if (!acc_i.legal) begin
      res_d = pgu_pkg::PGU_ILLEGAL;
    end else if (!acc_i.page_res) begin
      res_d = pgu_pkg::PGU_NOTRES;
    end
  end

  // Only an access that reaches memory marks usage; mapping off passes all.
  assign touch_d = acc_i.valid && (!map_en_i || res_d == pgu_pkg::PGU_OK);

  // Fault answer, one cycle after the access.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_err_o <= 1'b0;
      page_fault_o <= 1'b0;
      result_o <= pgu_pkg::PGU_OK;
      result_vld_o <= 1'b0;
    end else begin
      result_vld_o <= acc_i.valid && map_en_i;
      result_o <= map_en_i ? res_d : pgu_pkg::PGU_OK;
      bus_err_o <= acc_i.valid && map_en_i && res_d != pgu_pkg::PGU_OK;
      page_fault_o <= acc_i.valid && map_en_i && res_d == pgu_pkg::PGU_NOTRES;
    end
  end

  // Context numbers above fifteen processes are flagged while mapping is on; zero is unused.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctx_bad_o <= 1'b0;
    end else begin
      ctx_bad_o <= map_en_i && ctx_i > pgu_pkg::CTX_W'(pgu_pkg::MAX_PROCS);
    end
  end

  // ==========================================================================
  // Usage table update
  // ==========================================================================
  // Host marks are a read-modify-write over two cycles; a software write to the
  // marked page in the same window is merged so a host set is never lost under a clear.
  logic mark_q;
  logic mark_wr_q;
  logic [pgu_pkg::PAGE_NUM_W-1:0] mark_ppn_q;
  logic swr_q;
  logic [pgu_pkg::PAGE_NUM_W-1:0] sw_ppn_q;
  logic [1:0] rd_data;
  logic [pgu_pkg::PAGE_NUM_W-1:0] raddr;
  logic we;
  logic [pgu_pkg::PAGE_NUM_W-1:0] waddr;
  logic [1:0] wdata;
  logic [1:0] sw_val;
  logic last_we_q;
  logic [pgu_pkg::PAGE_NUM_W-1:0] last_waddr_q;
  logic [1:0] last_wdata_q;
  logic [1:0] mark_old;
  logic [1:0] swr_old;

  // Software value: bit 15 referenced, bit 14 modified.
  assign sw_val = {sw_i.ctl[pgu_pkg::CTL_REF_BIT], sw_i.ctl[pgu_pkg::CTL_MOD_BIT]};

  // Host access reads the page it translated to.
  assign raddr = touch_d ? acc_i.ppn : sw_i.ppn;

  // Stage host marks and software reads.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mark_q <= 1'b0;
      mark_wr_q <= 1'b0;
      mark_ppn_q <= '0;
      swr_q <= 1'b0;
      sw_ppn_q <= '0;
    end else begin
      mark_q <= touch_d;
      mark_wr_q <= acc_i.write;
      mark_ppn_q <= acc_i.ppn;
      swr_q <= sw_i.valid && !sw_i.write && !touch_d;
      sw_ppn_q <= sw_i.ppn;
    end
  end

  // The memory returns the old word when a read and a write of one page meet at
  // one edge, so the word just written is forwarded; otherwise back-to-back marks
  // on one page would lose the first set.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_we_q <= 1'b0;
      last_waddr_q <= '0;
      last_wdata_q <= pgu_pkg::USAGE_RST;
    end else begin
      last_we_q <= we;
      last_waddr_q <= waddr;
      last_wdata_q <= wdata;
    end
  end

  // Current word of the page being marked or read by software.
  assign mark_old = (last_we_q && last_waddr_q == mark_ppn_q) ? last_wdata_q : rd_data;
  assign swr_old = (last_we_q && last_waddr_q == sw_ppn_q) ? last_wdata_q : rd_data;

  // Write selection: software write lands directly, host mark ORs in.
  always_comb begin
    we = 1'b0;
    waddr = mark_ppn_q;
    wdata = rd_data;
    if (mark_q) begin
      we = 1'b1;
      wdata = mark_old | {1'b1, mark_wr_q};
      if (sw_i.valid && sw_i.write && sw_i.ppn == mark_ppn_q) begin
        wdata = sw_val | {1'b1, mark_wr_q};
      end
    end else if (sw_i.valid && sw_i.write) begin
      we = 1'b1;
      waddr = sw_i.ppn;
      wdata = sw_val;
    end
  end

  // A software write on another page than a pending mark is dropped; the
  // host must not issue a software write to another page in the cycle after an access.
  pgu_usage_ram #(
    .DEPTH(PAGES),
    .AW(pgu_pkg::PAGE_NUM_W)
  ) u_ram (
    .clk_i(clk_i),
    .raddr_i(raddr),
    .rdata_o(rd_data),
    .we_i(we),
    .waddr_i(waddr),
    .wdata_i(wdata)
  );

  // Software read answer.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sw_rdata_o <= pgu_pkg::USAGE_RST;
      sw_rvld_o <= 1'b0;
    end else begin
      sw_rvld_o <= swr_q;
      if (swr_q) begin
        sw_rdata_o <= swr_old;
      end
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  a_fault_on_table: assert property (@(posedge clk_i) disable iff (rst_i)
    acc_i.valid && map_en_i && acc_i.mapped && !acc_i.ptab_res |=> page_fault_o)
    else $error("Missing fault for absent page table.");
  a_unmapped_no_fault: assert property (@(posedge clk_i) disable iff (rst_i)
    acc_i.valid && map_en_i && !acc_i.mapped |=> bus_err_o && !page_fault_o)
    else $error("Unmapped segment reported as residency fault.");
  a_page_fault: assert property (@(posedge clk_i) disable iff (rst_i)
    acc_i.valid && map_en_i && acc_i.mapped && acc_i.ptab_res && acc_i.legal
    && !acc_i.page_res |=> page_fault_o && result_o == pgu_pkg::PGU_NOTRES)
    else $error("Missing fault for absent page.");
  a_illegal_first: assert property (@(posedge clk_i) disable iff (rst_i)
    acc_i.valid && map_en_i && acc_i.mapped && acc_i.ptab_res && !acc_i.legal
    |=> !page_fault_o && result_o == pgu_pkg::PGU_ILLEGAL)
    else $error("Illegal access reported as residency fault.");
  a_map_off_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    !map_en_i |=> !bus_err_o && !page_fault_o)
    else $error("Fault raised with mapping disabled.");
  a_err_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
    !acc_i.valid |=> !bus_err_o)
    else $error("Bus error without an access.");
  a_ref_set: assert property (@(posedge clk_i) disable iff (rst_i)
    touch_d |=> we && waddr == $past(acc_i.ppn) && wdata[1])
    else $error("Referenced flag not set on access.");
  a_mod_set: assert property (@(posedge clk_i) disable iff (rst_i)
    touch_d && acc_i.write |=> we && wdata[0])
    else $error("Modified flag not set on write.");
  a_sw_read: assert property (@(posedge clk_i) disable iff (rst_i)
    sw_i.valid && !sw_i.write && !touch_d |-> ##2 sw_rvld_o)
    else $error("Software read answer missing.");

  c_fault: cover property (@(posedge clk_i) page_fault_o);
  c_illegal: cover property (@(posedge clk_i) result_vld_o && result_o == pgu_pkg::PGU_ILLEGAL);
  c_write_mark: cover property (@(posedge clk_i) touch_d && acc_i.write);
  c_sw_merge: cover property (@(posedge clk_i) mark_q && sw_i.valid && sw_i.write);

endmodule // pgu_core

//--- dv/pgu_host_model.sv
`timescale 1ns/1ps

// Host side: issues translated accesses and software table operations.
module pgu_host_model (
  // Clock
  input wire logic clk_i,
  // Requests toward the block
  output pgu_pkg::pgu_access_t acc_o,
  output pgu_pkg::pgu_swop_t sw_o
);
  // ==========================================================================
  // Request tasks
  // ==========================================================================
  // Idle requests at time zero.
  initial begin
    acc_o = '0;
    sw_o = '0;
  end

  // One access for one cycle; released fields are inverted, not held, to expose stale use.
  task automatic access(input logic w, m, pt, lg, pr, input logic [11:0] pg);
    @(negedge clk_i);
    acc_o = '{1'b1, w, m, pt, lg, pr, pg};
    @(negedge clk_i);
    acc_o = {1'b0, ~acc_o[16:0]};
  endtask

  // Two accesses to one page on consecutive edges, write first, so the second
  // mark reads the page while the first one is still being written.
  task automatic access_pair(input logic [11:0] pg);
    @(negedge clk_i);
    acc_o = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, pg};
    @(negedge clk_i);
    acc_o.write = 1'b0;
    @(negedge clk_i);
    acc_o = {1'b0, ~acc_o[16:0]};
  endtask

  // One software table operation; the clearing write is how aging restarts.
  task automatic swop(input logic w, input logic [11:0] pg, input logic [15:0] ctl);
    @(negedge clk_i);
    sw_o = '{1'b1, w, pg, ctl};
    @(negedge clk_i);
    sw_o = {1'b0, ~sw_o[28:0]};
  endtask
endmodule // pgu_host_model

//--- dv/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin mismatches++; \
  $display("wrong value at %0t: got %h exp %h", $time, (a), (e)); end end

// Self-checking bench for the usage and fault logic.
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic map_en_i = 1'b1;
  logic [3:0] ctx_i = 4'hf;
  pgu_pkg::pgu_access_t acc_i;
  pgu_pkg::pgu_swop_t sw_i;
  logic bus_err_o;
  logic page_fault_o;
  pgu_pkg::pgu_result_t result_o;
  logic result_vld_o;
  logic [1:0] sw_rdata_o;
  logic sw_rvld_o;
  logic ctx_bad_o;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;

  // 20 MHz clock.
  always #25 clk_i = ~clk_i;

  pgu_host_model pgu_host_model_i (.clk_i(clk_i), .acc_o(acc_i), .sw_o(sw_i));
  pgu_core #(.PAGES(pgu_pkg::PAGE_COUNT)) pgu_core_i (.clk_i(clk_i), .rst_i(rst_i),
    .map_en_i(map_en_i), .ctx_i(ctx_i), .acc_i(acc_i), .sw_i(sw_i),
    .bus_err_o(bus_err_o), .page_fault_o(page_fault_o), .result_o(result_o),
    .result_vld_o(result_vld_o), .sw_rdata_o(sw_rdata_o), .sw_rvld_o(sw_rvld_o),
    .ctx_bad_o(ctx_bad_o));

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic stop_test();
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Access, then the one-cycle answer, which stands at the release negedge, then gone.
  task automatic acc_chk(input logic w, m, pt, lg, pr, input logic [11:0] pg,
                         input logic ev, ee, ep, input pgu_pkg::pgu_result_t er);
    pgu_host_model_i.access(w, m, pt, lg, pr, pg);
    `CHK(result_vld_o, ev)
    `CHK(bus_err_o, ee)
    `CHK(page_fault_o, ep)
    if (ev) begin
      `CHK(result_o, er)
    end
    @(negedge clk_i);
    `CHK(bus_err_o, 1'b0)
  endtask

  // Table read answered on the first edge after it is taken; the pulse stands
  // for one cycle, seen one negedge after the request is released.
  task automatic rd_chk(input logic [11:0] pg, input logic [1:0] exp);
    pgu_host_model_i.swop(1'b0, pg, 16'h0000);
    @(negedge clk_i);
    `CHK(sw_rvld_o, 1'b1)
    `CHK(sw_rdata_o, exp)
  endtask

  // Hang guard; the run needs under a hundred cycles.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      stop_test();
    end
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    repeat (12) @(negedge clk_i);
    rst_i = 1'b0;
    `CHK(bus_err_o, 1'b0)
    `CHK(ctx_bad_o, 1'b0)
    // Usage memory is not reset, so software clears the pages it uses.
    pgu_host_model_i.swop(1'b1, 12'h005, 16'h0000);
    pgu_host_model_i.swop(1'b1, 12'h006, 16'h0000);
    pgu_host_model_i.swop(1'b1, 12'hfff, 16'h0000);
    rd_chk(12'h005, 2'h0);
    acc_chk(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 12'h005, 1'b1, 1'b0, 1'b0, pgu_pkg::PGU_OK);
    rd_chk(12'h005, 2'h2);
    rd_chk(12'h006, 2'h0);
    acc_chk(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 12'h005, 1'b1, 1'b0, 1'b0, pgu_pkg::PGU_OK);
    acc_chk(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 12'h005, 1'b1, 1'b0, 1'b0, pgu_pkg::PGU_OK);
    rd_chk(12'h005, 2'h3);
    // Fault priorities on page 6.
    acc_chk(1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 12'h006, 1'b1, 1'b1, 1'b1, pgu_pkg::PGU_NOTRES);
    acc_chk(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 12'h006, 1'b1, 1'b1, 1'b1, pgu_pkg::PGU_NOTRES);
    acc_chk(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 12'h006, 1'b1, 1'b1, 1'b0, pgu_pkg::PGU_UNMAPPED);
    acc_chk(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 12'h006, 1'b1, 1'b1, 1'b0, pgu_pkg::PGU_ILLEGAL);
    rd_chk(12'h006, 2'h0);
    // Mapping off: no answer at all, yet usage is still logged.
    map_en_i = 1'b0;
    acc_chk(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 12'h006, 1'b0, 1'b0, 1'b0, pgu_pkg::PGU_OK);
    rd_chk(12'h006, 2'h3);
    map_en_i = 1'b1;
    // Software sets flags through the two control bits, as for a DMA target.
    pgu_host_model_i.swop(1'b1, 12'h007, 16'h8000);
    rd_chk(12'h007, 2'h2);
    pgu_host_model_i.swop(1'b1, 12'h007, 16'h4000);
    rd_chk(12'h007, 2'h1);
    // Back-to-back write then read on one page must keep the modified flag.
    pgu_host_model_i.swop(1'b1, 12'h008, 16'h0000);
    pgu_host_model_i.access_pair(12'h008);
    rd_chk(12'h008, 2'h3);
    // Top page of the table.
    acc_chk(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 12'hfff, 1'b1, 1'b0, 1'b0, pgu_pkg::PGU_OK);
    rd_chk(12'hfff, 2'h3);
    stop_test();
  end
endmodule // tb_top
